// ==== osc_pkg.sv ====
package osc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [31:0] OSC_REG_ADDR = 32'h190001a4;
  localparam logic [11:0] OSC_ADDR_MASK = 12'hffc;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int OSC_VD_BIT = 0;
  localparam int OSC_VC_BIT = 1;
  localparam int OSC_AUTO_RESET_ASSIST_BIT = 2;
  localparam int OSC_OT_BIT = 3;
  localparam int OSC_DP_BIT = 4;
  localparam int OSC_ID_PULLUP_CTL_BIT = 5;
  localparam int OSC_DATA_PULSE_ASSIST_BIT = 6;
  localparam int OSC_B_DISC_A_CONN_ASSIST_BIT = 7;
  localparam int OSC_ID_BIT = 8;
  localparam int OSC_AVV_BIT = 9;
  localparam int OSC_ASV_BIT = 10;
  localparam int OSC_BSV_BIT = 11;
  localparam int OSC_BSE_BIT = 12;
  localparam int OSC_MST_BIT = 13;
  localparam int OSC_DPS_BIT = 14;
  localparam int OSC_ID_CHANGE_IRQ_STATUS_BIT = 16;
  localparam int OSC_MSS_BIT = 21;
  localparam int OSC_ID_CHANGE_IRQ_ENABLE_BIT = 24;
  localparam int OSC_MSE_BIT = 29;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [7:0] OSC_CTL_RESET = 8'h20;
  localparam int OSC_CLK_HZ = 20000000;
  localparam int OSC_DEBOUNCE_US = 1000;
  localparam int OSC_MS_US = 1000;
  localparam int OSC_MS_CYCLES = OSC_CLK_HZ / 1000000 * OSC_MS_US;
  localparam int OSC_DEB_CYCLES = (OSC_CLK_HZ / 1000000 * OSC_DEBOUNCE_US) + 1;
  localparam int OSC_PULSE_US = 8;
  localparam int OSC_PULSE_CYCLES = OSC_CLK_HZ / 1000000 * OSC_PULSE_US;
  localparam int OSC_NSTAT = 6;

  // ****************************************
  // Grouped carriers
  // ****************************************
  typedef struct packed {
    logic data_pulse_seen;
    logic b_session_end;
    logic b_session_valid;
    logic a_session_valid;
    logic a_vbus_valid;
    logic usb_id;
  } osc_stat_s;

  typedef struct packed {
    logic vbus_discharge;
    logic vbus_charge;
    logic dm_pulldown;
    logic dp_pullup;
    logic id_pullup;
    logic auto_reset;
    logic b_disc_a_conn;
  } osc_phy_s;

  typedef enum logic [1:0] {
    OSC_RD_IDLE = 2'b00,
    OSC_RD_RESP = 2'b01
  } osc_rd_e;

endpackage

// ==== osc_otg_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module osc_otg_regs (
  input wire logic sys_clk, // 20 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire osc_pkg::osc_stat_s stat_in, // Raw comparator and ID inputs
  input wire logic host_connect, // Raw connect detect on host port
  output osc_pkg::osc_phy_s phy_ctl, // Transceiver control levels
  output logic host_reset_req, // Auto reset request after connect
  output logic dp_pulse_out, // Hardware data pulse on data-plus
  output logic otg_irq // OTG interrupt
);
  import osc_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  localparam int NSTAT_W = OSC_NSTAT;
  logic [7:0] ctl_q;
  logic [NSTAT_W-1:0] s1_q, s2_q, s3_q, deb_q;
  logic [NSTAT_W-1:0][15:0] cnt_q;
  logic [14:0] ms_cnt_q;
  logic ms_tick;
  logic ms_tog_q;
  logic id_irq_q, ms_irq_q, id_ie_q, ms_ie_q;
  logic id_prev_q;
  logic [7:0] pulse_cnt_q;
  logic [2:0] con_q;
  logic con_seen_q;
  logic aw_q, w_q;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go, wr_hit, rd_hit;
  osc_rd_e rd_q;

  // Address decode on word boundary
  function automatic logic hit(input logic [31:0] a);
    hit = (a & {20'hfffff, OSC_ADDR_MASK}) == OSC_REG_ADDR;
  endfunction

  // ****************************************
  // Input synchronisers and debounce
  // ****************************************
  // Three-stage synchroniser on every raw input
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      con_q <= '0;
    end else begin
      s1_q <= stat_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      con_q <= {con_q[1:0], host_connect};
    end
  end

  // Counter restarts on every disagreement; accept after more than 1 ms
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < NSTAT_W; i++) begin
      if (rst) begin
        cnt_q[i] <= '0;
        deb_q[i] <= 1'b0;
      end else if (s2_q[i] != s3_q[i] || s3_q[i] == deb_q[i]) begin
        cnt_q[i] <= '0;
      end else if (i == 0 && !ctl_q[OSC_ID_PULLUP_CTL_BIT]) begin
        cnt_q[i] <= '0;
      end else if (cnt_q[i] == 16'(OSC_DEB_CYCLES - 1)) begin
        cnt_q[i] <= '0;
        deb_q[i] <= s3_q[i];
      end else begin
        cnt_q[i] <= cnt_q[i] + 16'h0001;
      end
    end
  end

  // ****************************************
  // Millisecond timer
  // ****************************************
  assign ms_tick = (ms_cnt_q == 15'(OSC_MS_CYCLES - 1));

  // Free-running millisecond divider and toggle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ms_cnt_q <= '0;
      ms_tog_q <= 1'b0;
    end else if (ms_tick) begin
      ms_cnt_q <= '0;
      ms_tog_q <= ~ms_tog_q;
    end else begin
      ms_cnt_q <= ms_cnt_q + 15'h0001;
    end
  end

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  assign wr_hit = wr_go && hit(awaddr_q);

  // Capture address and data in either order
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= hit(awaddr_q) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Ready only while the holding slot is empty
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_q && !(s_axi_awvalid && s_axi_awready) && !wr_go;
      s_axi_wready <= !w_q && !(s_axi_wvalid && s_axi_wready) && !wr_go;
    end
  end

  // ****************************************
  // Control bits
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl_q <= OSC_CTL_RESET;
      id_ie_q <= 1'b0;
      ms_ie_q <= 1'b0;
    end else begin
      if (wr_hit && wstrb_q[0]) begin
        ctl_q <= wdata_q[7:0];
      end else if (ctl_q[OSC_DATA_PULSE_ASSIST_BIT] && pulse_cnt_q == 8'h01) begin
        ctl_q[OSC_DATA_PULSE_ASSIST_BIT] <= 1'b0;
      end
      if (wr_hit && wstrb_q[3]) begin
        id_ie_q <= wdata_q[OSC_ID_CHANGE_IRQ_ENABLE_BIT];
        ms_ie_q <= wdata_q[OSC_MSE_BIT];
      end
    end
  end

  // ****************************************
  // Hardware assist sequences
  // ****************************************
  // Data pulse timer started by a write of 1
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulse_cnt_q <= '0;
      dp_pulse_out <= 1'b0;
    end else if (wr_hit && wstrb_q[0] && wdata_q[OSC_DATA_PULSE_ASSIST_BIT]) begin
      pulse_cnt_q <= 8'(OSC_PULSE_CYCLES);
      dp_pulse_out <= 1'b1;
    end else if (pulse_cnt_q != 8'h00) begin
      pulse_cnt_q <= pulse_cnt_q - 8'h01;
      dp_pulse_out <= pulse_cnt_q != 8'h01;
    end
  end

  // Connect edge issues one reset request when assist on
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      con_seen_q <= 1'b0;
      host_reset_req <= 1'b0;
    end else begin
      if (con_q[1] == con_q[2]) begin
        con_seen_q <= con_q[2]; // Accepted level once stages agree
      end
      host_reset_req <= ctl_q[OSC_AUTO_RESET_ASSIST_BIT] && con_q[1] && con_q[2] && !con_seen_q;
    end
  end

  // Transceiver control levels
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phy_ctl <= '0;
    end else begin
      phy_ctl.vbus_discharge <= ctl_q[OSC_VD_BIT];
      phy_ctl.vbus_charge <= ctl_q[OSC_VC_BIT];
      phy_ctl.dm_pulldown <= ctl_q[OSC_OT_BIT];
      phy_ctl.dp_pullup <= ctl_q[OSC_DP_BIT] | dp_pulse_out;
      phy_ctl.id_pullup <= ctl_q[OSC_ID_PULLUP_CTL_BIT];
      phy_ctl.auto_reset <= ctl_q[OSC_AUTO_RESET_ASSIST_BIT];
      phy_ctl.b_disc_a_conn <= ctl_q[OSC_B_DISC_A_CONN_ASSIST_BIT];
    end
  end

  // ****************************************
  // Interrupt status, set wins over clear
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      id_prev_q <= 1'b0;
      id_irq_q <= 1'b0;
      ms_irq_q <= 1'b0;
      otg_irq <= 1'b0;
    end else begin
      id_prev_q <= deb_q[0];
      if (deb_q[0] != id_prev_q) begin
        id_irq_q <= 1'b1;
      end else if (wr_hit && wstrb_q[2] && wdata_q[OSC_ID_CHANGE_IRQ_STATUS_BIT]) begin
        id_irq_q <= 1'b0;
      end
      if (ms_tick) begin
        ms_irq_q <= 1'b1;
      end else if (wr_hit && wstrb_q[2] && wdata_q[OSC_MSS_BIT]) begin
        ms_irq_q <= 1'b0;
      end
      otg_irq <= (id_irq_q && id_ie_q) || (ms_irq_q && ms_ie_q);
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  assign rd_hit = hit(s_axi_araddr);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_q <= OSC_RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else begin
      unique case (rd_q)
        OSC_RD_IDLE: begin
          s_axi_arready <= !s_axi_arready;
          if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
            s_axi_rdata <= '0;
            if (rd_hit) begin
              s_axi_rdata[7:0] <= ctl_q;
              s_axi_rdata[OSC_ID_BIT] <= deb_q[0];
              s_axi_rdata[OSC_AVV_BIT] <= deb_q[1];
              s_axi_rdata[OSC_ASV_BIT] <= deb_q[2];
              s_axi_rdata[OSC_BSV_BIT] <= deb_q[3];
              s_axi_rdata[OSC_BSE_BIT] <= deb_q[4];
              s_axi_rdata[OSC_MST_BIT] <= ms_tog_q;
              s_axi_rdata[OSC_DPS_BIT] <= deb_q[5];
              s_axi_rdata[OSC_ID_CHANGE_IRQ_STATUS_BIT] <= id_irq_q;
              s_axi_rdata[OSC_MSS_BIT] <= ms_irq_q;
              s_axi_rdata[OSC_ID_CHANGE_IRQ_ENABLE_BIT] <= id_ie_q;
              s_axi_rdata[OSC_MSE_BIT] <= ms_ie_q;
            end
            rd_q <= OSC_RD_RESP;
          end
        end
        OSC_RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_q <= OSC_RD_IDLE;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== osc_otg_regs_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module osc_otg_asserts (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Aw valid
  input wire logic s_axi_awready, // Aw ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Ar valid
  input wire logic s_axi_arready, // Ar ready
  input wire logic [1:0] s_axi_bresp, // Write resp
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [1:0] s_axi_rresp, // Read resp
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire logic host_connect, // Raw connect
  input wire osc_pkg::osc_phy_s phy_ctl, // Phy controls
  input wire logic host_reset_req, // Reset request
  input wire logic dp_pulse_out, // Data pulse
  input wire logic otg_irq // Interrupt
);
  import osc_pkg::*;
  logic aw_bad_q;
  logic ar_bad_q;
  logic [15:0] conn_q;
  logic [7:0] hi_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Remember address decode of each request
  always_ff @(posedge sys_clk) begin
    if (s_axi_awvalid && s_axi_awready) aw_bad_q <= s_axi_awaddr[31:2] != OSC_REG_ADDR[31:2];
    if (s_axi_arvalid && s_axi_arready) ar_bad_q <= s_axi_araddr[31:2] != OSC_REG_ADDR[31:2];
  end
  // Cycles of steady raw connect
  always_ff @(posedge sys_clk) begin
    if (!host_connect) conn_q <= 16'h0;
    else if (conn_q != 16'hffff) conn_q <= conn_q + 16'h1;
  end
  // Length of current data pulse
  always_ff @(posedge sys_clk) begin
    hi_q <= dp_pulse_out ? hi_q + 8'h1 : 8'h0;
  end
  reset_state_a: assert property ($fell(rst) |-> !otg_irq && !dp_pulse_out ##1 phy_ctl == 7'h04)
    else $error("control outputs wrong after reset");
  req_pulse_a: assert property (host_reset_req |=> !host_reset_req)
    else $error("reset request longer than one cycle");
  req_enable_a: assert property (host_reset_req |-> phy_ctl.auto_reset)
    else $error("reset request while assist off");
  conn_lat_a: assert property (host_reset_req |-> conn_q == 16'h0004)
    else $error("reset request not four cycles after connect");
  pulse_len_a: assert property ($fell(dp_pulse_out) |-> hi_q == 8'ha0)
    else $error("data pulse length wrong");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  wr_resp_a: assert property (s_axi_bvalid |-> s_axi_bresp == (aw_bad_q ? 2'h2 : 2'h0))
    else $error("write response code wrong");
  rd_resp_a: assert property (s_axi_rvalid |-> s_axi_rresp == (ar_bad_q ? 2'h2 : 2'h0))
    else $error("read response code wrong");
  cover property (host_reset_req);
  cover property ($fell(dp_pulse_out));
  cover property (s_axi_rvalid && ar_bad_q);
endmodule
bind osc_otg_regs osc_otg_asserts chk_u (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .host_connect(host_connect), .phy_ctl(phy_ctl), .host_reset_req(host_reset_req),
  .dp_pulse_out(dp_pulse_out), .otg_irq(otg_irq));
`default_nettype wire

// ==== osc_phy_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module osc_phy_model (
  input wire logic sys_clk, // Clock
  input wire osc_pkg::osc_stat_s lvl, // Wanted line levels
  input wire osc_pkg::osc_phy_s phy_ctl, // Controls from block
  output osc_pkg::osc_stat_s stat_in // Levels seen by block
);
  import osc_pkg::*;
  initial stat_in = '0;
  // Comparators follow the bus; ID floats without its pull-up
  always @(posedge sys_clk) begin
    stat_in <= lvl;
    if (!phy_ctl.id_pullup) stat_in.usb_id <= ~stat_in.usb_id;
  end
endmodule
`default_nettype wire

// ==== otg_status_control_reg_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module otg_status_control_reg_bench;
  import osc_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} osc_exp_s;
  logic sys_clk = 1'b0, rst = 1'b1, conn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, ctl;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, req, pulse, irq;
  logic [1:0] bresp, rresp;
  osc_stat_s lvl = '0, stat;
  osc_phy_s phy;
  osc_exp_s rq[$], ex;
  logic [1:0] bq[$];
  int error_cnt = 0, tests_run = 0, seed = 4552, n, reqs = 0, hi_n = 0;
  osc_otg_regs dut_u (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .stat_in(stat),
    .host_connect(conn), .phy_ctl(phy), .host_reset_req(req), .dp_pulse_out(pulse), .otg_irq(irq));
  osc_phy_model pm_u (.sys_clk(sys_clk), .lvl(lvl), .phy_ctl(phy), .stat_in(stat));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("Checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ********
  // Bus tasks
  // ********
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge sys_clk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge sys_clk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    while (!bvalid) @(posedge sys_clk);
    bready <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    rq.push_back('{d, m, r});
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (!rvalid);
    rready <= 1'b0;
  endtask
  function automatic logic [31:0] pmap(input logic [7:0] c);
    return {25'h0, c[0], c[1], c[3], c[4], c[5], c[2], c[7]};
  endfunction
  // Compare responses with the oldest notes
  always @(posedge sys_clk) begin
    if (bvalid && bready) check("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
    if (rvalid && rready) begin
      ex = rq.pop_front();
      check("rdata", rdata & ex.m, ex.d & ex.m);
      check("rresp", {30'h0, rresp}, {30'h0, ex.r});
    end
    if (req === 1'b1) reqs++;
    if (pulse === 1'b1) hi_n++;
  end
  // ********
  // Scenarios
  // ********
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(OSC_REG_ADDR, 32'h20, 32'hffffffff, 2'h0);
    for (n = 0; n < 4; n++) begin
      ctl = $random(seed) & 32'hbf;
      wr(OSC_REG_ADDR, ctl, 2'h0);
      check("phy", {25'h0, phy}, pmap(ctl[7:0]));
      rd(OSC_REG_ADDR, ctl, 32'hff, 2'h0);
    end
    wr(OSC_REG_ADDR + 32'h4, 32'hff, 2'h2);
    rd(OSC_REG_ADDR, ctl, 32'hff, 2'h0);
    rd(OSC_REG_ADDR - 32'h4, 32'h0, 32'hffffffff, 2'h2);
    wr(OSC_REG_ADDR, 32'h6c, 2'h0);
    repeat (200) @(posedge sys_clk);
    check("pulse", hi_n, 32'ha0);
    rd(OSC_REG_ADDR, 32'h2c, 32'hff, 2'h0);
    lvl <= 6'h3f;
    conn <= 1'b1;
    repeat (10000) @(posedge sys_clk);
    lvl <= 6'h0;
    conn <= 1'b0;
    repeat (20100) @(posedge sys_clk);
    rd(OSC_REG_ADDR, 32'h0, 32'h15f00, 2'h0);
    lvl <= 6'h2f;
    conn <= 1'b1;
    repeat (19000) @(posedge sys_clk);
    rd(OSC_REG_ADDR, 32'h0, 32'h15f00, 2'h0);
    repeat (1200) @(posedge sys_clk);
    rd(OSC_REG_ADDR, 32'h214f00, 32'h215f00, 2'h0);
    check("reqs", reqs, 32'h2);
    check("irq", {31'h0, irq}, 32'h0);
    wr(OSC_REG_ADDR, 32'h0100002c, 2'h0);
    check("irq", {31'h0, irq}, 32'h1);
    rd(OSC_REG_ADDR, 32'h0121002c, 32'h012100ff, 2'h0);
    wr(OSC_REG_ADDR, 32'h0121002c, 2'h0);
    rd(OSC_REG_ADDR, 32'h0100002c, 32'h012100ff, 2'h0);
    check("irq", {31'h0, irq}, 32'h0);
    wstrb <= 4'h1;
    wr(OSC_REG_ADDR, 32'h20000020, 2'h0);
    wstrb <= 4'hf;
    rd(OSC_REG_ADDR, 32'h01000020, 32'h210000ff, 2'h0);
    print_verdict();
  end
  // Cut a hung run short
  initial begin
    repeat (80000) @(posedge sys_clk);
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
